// ### mbpc_defines.vh
// constants for the motor bridge pwm control block
`ifndef MBPC_DEFINES_VH
`define MBPC_DEFINES_VH

// register indices (byte address = 4 * index)
`define MBPC_ADDR_CTRL    4'h0
`define MBPC_ADDR_CONFIG  4'h1
`define MBPC_ADDR_STATUS  4'h2
`define MBPC_ADDR_IRQ     4'h3
`define MBPC_ADDR_MASK    4'h4

// control register fields
`define MBPC_CTRL_DIR_A   0
`define MBPC_CTRL_DIR_B   1
`define MBPC_CTRL_DIR_C   2
`define MBPC_CTRL_HS1     3
`define MBPC_CTRL_HS2     4
`define MBPC_CTRL_LS1     5
`define MBPC_CTRL_LS2     6
`define MBPC_CTRL_RST     7'h00

// configuration register fields
`define MBPC_CFG_HSSEL1   0
`define MBPC_CFG_HSSEL2   1
`define MBPC_CFG_C_DC     13
`define MBPC_CFG_RST      16'h0000

// interrupt bits: limit a, b, c, thermal a, b, c, overvoltage
`define MBPC_IRQ_W        7
`define MBPC_IRQ_RST      7'h00

// timing
`define MBPC_CLK_MHZ      25
`define MBPC_DEGLITCH_NS  500
`define MBPC_DEGLITCH_CYC ((`MBPC_DEGLITCH_NS * `MBPC_CLK_MHZ + 999) / 1000)
`define MBPC_OSC_KHZ      200
`define MBPC_OSC_DIV      ((`MBPC_CLK_MHZ * 1000) / `MBPC_OSC_KHZ)
`define MBPC_OFF_TICKS    25

`endif

// ### mbpc_sync.v
// two-stage synchroniser for one level
`timescale 1ns/10ps
`default_nettype none

module mbpc_sync (
  input  wire clk,    // block clock
  input  wire rstn,   // async reset, active low
  input  wire d,      // asynchronous level
  output reg  q       // synchronised level
);

  reg meta_reg;       // first stage, read only by q

  // two flip-flops in a row; reset low so an idle input reads as off
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_reg <= 1'b0;
      q        <= 1'b0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule // mbpc_sync

`default_nettype wire

// ### mbpc_limit.v
// current-limit deglitch and off-timer for one bridge
`timescale 1ns/10ps
`default_nettype none
`include "mbpc_defines.vh"

module mbpc_limit #(
  parameter DEGLITCH = `MBPC_DEGLITCH_CYC,  // deglitch cycles
  parameter OFF_TICKS = `MBPC_OFF_TICKS     // off period in osc ticks
) (
  input  wire clk,       // block clock
  input  wire rstn,      // async reset, active low
  input  wire tick,      // 200 khz oscillator tick
  input  wire over_cur,  // raw overcurrent indication
  output reg  hold_off,  // bridge forced off
  output reg  event_p    // qualified limit event pulse
);

  reg [7:0] glitch_reg;  // deglitch counter
  reg [7:0] off_reg;     // off-timer ticks left

  // filter, then hold the bridge off for a fixed number of ticks
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      glitch_reg <= 8'h00;
      off_reg    <= 8'h00;
      hold_off   <= 1'b0;
      event_p    <= 1'b0;
    end else begin
      event_p <= 1'b0;
      if (!over_cur || hold_off)
        glitch_reg <= 8'h00;
      else if (glitch_reg != DEGLITCH[7:0])
        glitch_reg <= glitch_reg + 8'h01;                      // [RULE9]
      if (!hold_off && over_cur && glitch_reg == DEGLITCH[7:0]) begin
        hold_off <= 1'b1;                                      // [RULE10]
        off_reg  <= OFF_TICKS[7:0];
        event_p  <= 1'b1;
      end else if (hold_off && tick) begin
        if (off_reg == 8'h01)
          hold_off <= 1'b0;                                    // [RULE17]
        off_reg <= off_reg - 8'h01;
      end
    end
  end

endmodule // mbpc_limit

`default_nettype wire

// ### mbpc_top.v
// motor bridge pwm control: drivers a, b and configurable driver c
`timescale 1ns/10ps
`default_nettype none
`include "mbpc_defines.vh"

// Operation
// RULE1: bridge a outputs follow its pulse input
// RULE2: bridge b outputs follow its own input
// RULE3: dc mode: first c input, register direction
// RULE4: stepper: phase a first, phase b second
// RULE5: config bit 13: 0 stepper, 1 dc
// RULE6: dc low-side or stepper high-side outputs
// RULE7: c outputs selectable as high-side outputs
// RULE8: stepper off when supply over 20 v
// RULE9: overcurrent deglitched before limit event
// RULE10: off-timer holds bridge off after limit
// RULE11: direction reversal accepted under current
// RULE12: undriven pulse input means off
// RULE13: thermal shutdown disables that driver
// RULE14: host pulses at 20 to 40 khz
// RULE15: reset: stepper off, dc low-sides on
// RULE16: host writes direction, device applies it
// RULE17: resume after off-timer ticks expire
// RULE18: pulse inputs pass two-stage synchroniser
module mbpc_top #(
  parameter OFF_TICKS = `MBPC_OFF_TICKS   // off-timer length in osc ticks
) (
  input  wire        clk,                       // 25 mhz clock
  input  wire        rstn,                      // async reset, active low
  input  wire [3:0]  addr,                      // register index
  input  wire [31:0] wdata,                     // write data
  input  wire        wr,                        // write strobe
  input  wire        rd,                        // read strobe
  output reg  [31:0] rdata,                     // read data, cycle after rd
  input  wire        bridge_a_pulse_in,         // driver a pwm
  input  wire        bridge_b_pulse_in,         // driver b pwm
  input  wire        driver_c_pulse_in_first,   // driver c pwm first
  input  wire        driver_c_pulse_in_second,  // driver c pwm second
  input  wire [2:0]  over_cur,                  // overcurrent a, b, c
  input  wire [2:0]  over_temp,                 // thermal a, b, c
  input  wire        supply_over_20v,           // supervisor: b+ > 20 v
  output reg  [3:0]  bridge_a_outputs,          // hs1 ls1 hs2 ls2
  output reg  [3:0]  bridge_b_outputs,          // hs1 ls1 hs2 ls2
  output reg  [3:0]  driver_c_gates,            // hs1 ls1 hs2 ls2
  output reg         driver_c_out_first,        // leg 1 high side on
  output reg         driver_c_out_second,       // leg 2 high side on
  output reg         irq                        // interrupt, active high
);

  // bridge gate vector bit positions
  localparam G_HS1 = 3;
  localparam G_LS1 = 2;
  localparam G_HS2 = 1;
  localparam G_LS2 = 0;

  reg  [6:0]  ctrl_reg;       // directions and general outputs
  reg  [15:0] cfg_reg;        // mode and output selects
  reg  [6:0]  irq_reg;        // sticky events
  reg  [6:0]  mask_reg;       // interrupt enables
  reg  [6:0]  ev_next;        // events this cycle
  reg  [3:0]  c_next;         // driver c gates next
  reg  [15:0] div_reg;        // oscillator divider
  reg         tick_reg;       // 200 khz tick
  reg  [2:0]  temp_reg;       // registered thermal flags
  reg         ov_reg;         // registered overvoltage
  reg         ov_prev_reg;    // overvoltage edge detect
  reg  [2:0]  temp_prev_reg;  // thermal edge detect
  wire        pa;             // synchronised pulses
  wire        pb;
  wire        pc1;
  wire        pc2;
  wire [2:0]  hold;           // off-timer active per driver
  wire [2:0]  lim_ev;         // limit events

  // h-bridge gates: pwm on drives diagonal, pwm off brakes low-side
  function [3:0] mbpc_bridge;
    input pwm;
    input dir;
    input off;
    begin
      if (off)
        mbpc_bridge = 4'h0;
      else if (!pwm)
        mbpc_bridge = 4'h5;                       // both low-sides on
      else if (dir)
        mbpc_bridge = 4'h9;                       // hs1 and ls2
      else
        mbpc_bridge = 4'h6;                       // ls1 and hs2
    end
  endfunction

  // pulse inputs resynchronised; reset value low reads as off [RULE18] [RULE12]
  mbpc_sync u_sa (.clk(clk), .rstn(rstn), .d(bridge_a_pulse_in), .q(pa));
  mbpc_sync u_sb (.clk(clk), .rstn(rstn), .d(bridge_b_pulse_in), .q(pb));
  mbpc_sync u_s1 (.clk(clk), .rstn(rstn),
                  .d(driver_c_pulse_in_first), .q(pc1));
  mbpc_sync u_s2 (.clk(clk), .rstn(rstn),
                  .d(driver_c_pulse_in_second), .q(pc2));

  // 200 khz time base for the off-timers
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      div_reg  <= 16'h0000;
      tick_reg <= 1'b0;
    end else if (div_reg == `MBPC_OSC_DIV - 1) begin
      div_reg  <= 16'h0000;
      tick_reg <= 1'b1;
    end else begin
      div_reg  <= div_reg + 16'h0001;
      tick_reg <= 1'b0;
    end
  end

  // current-limit filter and off-timer per driver
  mbpc_limit #(.OFF_TICKS(OFF_TICKS)) u_la (
    .clk(clk), .rstn(rstn), .tick(tick_reg), .over_cur(over_cur[0]),
    .hold_off(hold[0]), .event_p(lim_ev[0]));
  mbpc_limit #(.OFF_TICKS(OFF_TICKS)) u_lb (
    .clk(clk), .rstn(rstn), .tick(tick_reg), .over_cur(over_cur[1]),
    .hold_off(hold[1]), .event_p(lim_ev[1]));
  mbpc_limit #(.OFF_TICKS(OFF_TICKS)) u_lc (
    .clk(clk), .rstn(rstn), .tick(tick_reg), .over_cur(over_cur[2]),
    .hold_off(hold[2]), .event_p(lim_ev[2]));

  // fault inputs registered and edge-detected for events
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      temp_reg      <= 3'h0;
      temp_prev_reg <= 3'h0;
      ov_reg        <= 1'b0;
      ov_prev_reg   <= 1'b0;
    end else begin
      temp_reg      <= over_temp;
      temp_prev_reg <= temp_reg;
      ov_reg        <= supply_over_20v;
      ov_prev_reg   <= ov_reg;
    end
  end

  // event vector: limit a b c, thermal a b c, overvoltage
  always @* begin
    ev_next = {ov_reg & ~ov_prev_reg, temp_reg & ~temp_prev_reg, lim_ev};
  end

  // driver c gate selection by mode
  always @* begin
    c_next = 4'h0;
    if (cfg_reg[`MBPC_CFG_C_DC]) begin                         // [RULE5]
      // dc bridge, direction from register, gated by first input
      c_next = mbpc_bridge(pc1, ctrl_reg[`MBPC_CTRL_DIR_C],
                           temp_reg[2] | hold[2]);             // [RULE3] [RULE16]
      // a leg selected as general high-side leaves the bridge
      if (cfg_reg[`MBPC_CFG_HSSEL1]) begin
        c_next[G_HS1] = ctrl_reg[`MBPC_CTRL_HS1];              // [RULE7]
        c_next[G_LS1] = ctrl_reg[`MBPC_CTRL_LS1];              // [RULE6]
      end
      if (cfg_reg[`MBPC_CFG_HSSEL2]) begin
        c_next[G_HS2] = ctrl_reg[`MBPC_CTRL_HS2];              // [RULE7]
        c_next[G_LS2] = ctrl_reg[`MBPC_CTRL_LS2];              // [RULE6]
      end
      if (temp_reg[2])
        c_next = 4'h0;                                         // [RULE13]
    end else if (!ov_reg && !temp_reg[2] && !hold[2]) begin    // [RULE8]
      // stepper: phase a on ls1 side, phase b on ls2 side
      c_next[G_LS1] = pc1;                                     // [RULE4]
      c_next[G_LS2] = pc2;                                     // [RULE4]
      c_next[G_HS1] = ctrl_reg[`MBPC_CTRL_HS1];                // [RULE6]
      c_next[G_HS2] = ctrl_reg[`MBPC_CTRL_HS2];                // [RULE6]
    end
  end

  // gate outputs; reset forces dc low-sides on, stepper off [RULE15]
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bridge_a_outputs    <= 4'h5;
      bridge_b_outputs    <= 4'h5;
      driver_c_gates      <= 4'h0;
      driver_c_out_first  <= 1'b0;
      driver_c_out_second <= 1'b0;
    end else begin
      // direction applied at once, even while current flows [RULE11]
      bridge_a_outputs <= mbpc_bridge(pa, ctrl_reg[`MBPC_CTRL_DIR_A],
                                      temp_reg[0] | hold[0]); // [RULE1] [RULE13]
      bridge_b_outputs <= mbpc_bridge(pb, ctrl_reg[`MBPC_CTRL_DIR_B],
                                      temp_reg[1] | hold[1]); // [RULE2] [RULE13]
      driver_c_gates      <= c_next;
      driver_c_out_first  <= c_next[G_HS1];
      driver_c_out_second <= c_next[G_HS2];
    end
  end

  // register writes; status set wins over write-one-to-clear
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_reg <= `MBPC_CTRL_RST;
      cfg_reg  <= `MBPC_CFG_RST;
      irq_reg  <= `MBPC_IRQ_RST;
      mask_reg <= `MBPC_IRQ_RST;
    end else begin
      if (wr && addr == `MBPC_ADDR_CTRL)
        ctrl_reg <= wdata[6:0];                                // [RULE16]
      if (wr && addr == `MBPC_ADDR_CONFIG)
        cfg_reg <= wdata[15:0];
      if (wr && addr == `MBPC_ADDR_MASK)
        mask_reg <= wdata[6:0];
      if (wr && addr == `MBPC_ADDR_IRQ)
        irq_reg <= (irq_reg & ~wdata[6:0]) | ev_next;
      else
        irq_reg <= irq_reg | ev_next;
    end
  end

  // read data one cycle after strobe, zero otherwise
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata <= 32'h00000000;
    end else if (rd) begin
      case (addr)
        `MBPC_ADDR_CTRL:   rdata <= {25'h0000000, ctrl_reg};
        `MBPC_ADDR_CONFIG: rdata <= {16'h0000, cfg_reg};
        `MBPC_ADDR_STATUS: rdata <= {19'h00000, driver_c_gates,
                                     ov_reg, temp_reg, hold, pc2, pc1};
        `MBPC_ADDR_IRQ:    rdata <= {25'h0000000, irq_reg};
        `MBPC_ADDR_MASK:   rdata <= {25'h0000000, mask_reg};
        default:           rdata <= 32'h00000000;
      endcase
    end else begin
      rdata <= 32'h00000000;
    end
  end

  // level interrupt from masked sticky status
  always @(posedge clk or negedge rstn) begin
    if (!rstn)
      irq <= 1'b0;
    else
      irq <= |(irq_reg & mask_reg);
  end

endmodule // mbpc_top

`default_nettype wire

// ### mbpc_props.sv
// assertion checker for the motor bridge pwm control top
`timescale 1ns/10ps
`default_nettype none
module mbpc_props (
  input wire logic        clk,                  // block clock
  input wire logic        rstn,                 // reset, active low
  input wire logic        rd,                   // read strobe
  input wire logic [31:0] rdata,                // read data
  input wire logic        bridge_a_pulse_in,    // driver a pwm
  input wire logic        bridge_b_pulse_in,    // driver b pwm
  input wire logic [2:0]  over_temp,            // thermal a, b, c
  input wire logic [3:0]  bridge_a_outputs,     // driver a gates
  input wire logic [3:0]  bridge_b_outputs,     // driver b gates
  input wire logic [3:0]  driver_c_gates,       // driver c gates
  input wire logic        driver_c_out_first,   // leg 1 high side
  input wire logic        driver_c_out_second   // leg 2 high side
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // safe state on leaving reset, pulse tracking, thermal cut-off
  a_reset_safe: assert property ($rose(rstn) |->
    bridge_a_outputs == 4'h5 && bridge_b_outputs == 4'h5
    && driver_c_gates == 4'h0) else $error("reset state wrong");
  a_a_follow: assert property (bridge_a_pulse_in [*4] |->
    bridge_a_outputs != 4'h5) else $error("bridge a not driven");
  a_a_idle: assert property (!bridge_a_pulse_in [*4] |->
    bridge_a_outputs inside {4'h5, 4'h0}) else $error("bridge a on");
  a_b_follow: assert property (bridge_b_pulse_in [*4] |->
    bridge_b_outputs != 4'h5) else $error("bridge b not driven");
  a_temp_a: assert property (over_temp[0] [*4] |->
    bridge_a_outputs == 4'h0) else $error("bridge a hot but on");
  a_temp_b: assert property (over_temp[1] [*4] |->
    bridge_b_outputs == 4'h0) else $error("bridge b hot but on");
  a_hs_copy: assert property (
    driver_c_out_first == driver_c_gates[3]
    && driver_c_out_second == driver_c_gates[1])
    else $error("high side outputs differ from gates");
  a_rdata_idle: assert property (!$past(rd) |->
    rdata == 32'h0) else $error("read data outside read");
endmodule // mbpc_props
bind mbpc_top mbpc_props chk (.clk, .rstn, .rd, .rdata, .bridge_a_pulse_in,
  .bridge_b_pulse_in, .over_temp, .bridge_a_outputs, .bridge_b_outputs,
  .driver_c_gates, .driver_c_out_first, .driver_c_out_second);
`default_nettype wire

// ### mbpc_host.sv
// host side pwm source for the four pulse inputs
`timescale 1ns/10ps
`default_nettype none
module mbpc_host #(
  parameter PER = 1000             // pwm period in clocks, 25 khz
) (
  input  wire logic       clk,     // block clock
  input  wire logic [3:0] en,      // channel enables
  input  wire logic [9:0] on_cyc,  // high time per period
  output var  logic [3:0] pwm      // a, b, c first, c second
);
  logic [9:0] cnt = 10'h000;
  // period counter; outputs change just after the edge
  always @(posedge clk) begin
    cnt <= (cnt >= PER - 1) ? 10'h000 : cnt + 10'h001;
    pwm <= en & {4{cnt < on_cyc}};
  end
  initial pwm = 4'h0;
endmodule // mbpc_host
`default_nettype wire

// ### mbpc_top_test.sv
// self-checking bench for the motor bridge pwm control top
`timescale 1ns/10ps
`default_nettype none
module mbpc_top_test;
  logic        clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0;
  logic        ov20 = 1'b0, c1, c2, irq;
  logic [3:0]  addr = 4'h0, en = 4'h0, ga, gb, gc, pw;
  logic [2:0]  oc = 3'h0, ot = 3'h0;
  logic [31:0] wdata = 32'h0, rdata, v;
  int          err_count = 0, checked = 0, i;

  logic [9:0]  duty = 10'h3FF;
  mbpc_host host (.clk(clk), .en(en), .on_cyc(duty), .pwm(pw));
  mbpc_top #(.OFF_TICKS(2)) dut (.clk(clk), .rstn(rstn), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .bridge_a_pulse_in(pw[0]), .bridge_b_pulse_in(pw[1]),
    .driver_c_pulse_in_first(pw[2]), .driver_c_pulse_in_second(pw[3]),
    .over_cur(oc), .over_temp(ot), .supply_over_20v(ov20),
    .bridge_a_outputs(ga), .bridge_b_outputs(gb), .driver_c_gates(gc),
    .driver_c_out_first(c1), .driver_c_out_second(c2), .irq(irq));

  // 25 mhz clock
  always #20 clk = ~clk;

  // helpers: compare, wait, register access, input setting
  task automatic chk(input logic [31:0] s, e);
    checked++;
    if (s !== e) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [3:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic setin(input logic [3:0] e, input logic [2:0] c, t,
                       input logic o);
    @(posedge clk);
    en <= e;
    oc <= c;
    ot <= t;
    ov20 <= o;
  endtask
  function automatic logic [3:0] leg(input logic d);
    return d ? 4'h9 : 4'h6;
  endfunction

  // bridges a and b: every direction, reversed while driving
  task automatic t_bridge;
    setin(4'h3, 3'h0, 3'h0, 1'b0);
    for (i = 0; i < 4; i++) begin
      wreg(4'h0, 32'(i));
      cyc(6);
      chk({ga, gb}, {leg(i[0]), leg(i[1])});
    end
    setin(4'h1, 3'h0, 3'h0, 1'b0);
    cyc(6);
    chk({ga, gb}, 8'h95);
  endtask

  // driver c stepper then dc mode, overvoltage, high-side select
  task automatic t_drvc;
    wreg(4'h1, 32'h0);
    wreg(4'h0, 32'h8);
    setin(4'hC, 3'h0, 3'h0, 1'b0);
    cyc(6);
    chk({gc, c1, c2}, 6'h36);
    setin(4'h4, 3'h0, 3'h0, 1'b1);
    cyc(6);
    chk(gc, 4'h0);
    wreg(4'h1, 32'h2000);
    wreg(4'h0, 32'h4);
    cyc(6);
    chk(gc, 4'h9);
    wreg(4'h0, 32'h0);
    cyc(4);
    chk(gc, 4'h6);
    wreg(4'h1, 32'h2003);
    wreg(4'h0, 32'h18);
    cyc(4);
    chk({gc, c1, c2}, 6'h2B);
    wreg(4'h0, 32'h60);
    cyc(4);
    chk({gc, c1, c2}, 6'h14);
  endtask

  // thermal cut-off with sticky status, mask and clear
  task automatic t_temp;
    wreg(4'h0, 32'h3);
    wreg(4'h3, 32'h7F);
    setin(4'h1, 3'h0, 3'h1, 1'b0);
    cyc(6);
    chk({ga, irq}, 5'h0);
    rreg(4'h3);
    chk(v, 32'h8);
    wreg(4'h4, 32'h8);
    cyc(2);
    chk(irq, 1'b1);
    setin(4'h1, 3'h0, 3'h0, 1'b0);
    wreg(4'h3, 32'h8);
    cyc(6);
    chk({ga, irq}, 5'h12);
  endtask

  // current limit: short glitch ignored, long one holds bridge b off
  task automatic t_limit;
    setin(4'h2, 3'h2, 3'h0, 1'b0);
    cyc(9);
    setin(4'h2, 3'h0, 3'h0, 1'b0);
    rreg(4'h3);
    chk({v[1], gb}, 5'h9);
    setin(4'h2, 3'h2, 3'h0, 1'b0);
    cyc(20);
    setin(4'h2, 3'h0, 3'h0, 1'b0);
    rreg(4'h3);
    chk({v[1], gb}, 5'h10);
    cyc(90);
    chk(gb, 4'h0);
    for (i = 0; i < 400 && gb !== 4'h9; i++) cyc(1);
    chk(gb, 4'h9);
    if (i == 400) final_report;
    rreg(4'hF);
    chk(v, 32'h0);
  endtask

  // readback, status word, thermal b and c, overvoltage event
  task automatic t_stat;
    rreg(4'h0);
    chk(v, 32'h3);
    rreg(4'h1);
    chk(v, 32'h2003);
    setin(4'h4, 3'h0, 3'h6, 1'b1);
    cyc(6);
    chk({gb, gc, c1, c2}, 10'h000);
    rreg(4'h2);
    chk(v, 32'h1C1);
    rreg(4'h3);
    chk(v, 32'h72);
    setin(4'h0, 3'h0, 3'h0, 1'b0);
    wreg(4'h3, 32'h7F);
    cyc(4);
    rreg(4'h3);
    chk(v, 32'h0);
  endtask

  // driver a tracks a toggling pwm train three clocks late
  task automatic t_pwm;
    int j;
    logic [2:0] h;
    wreg(4'h0, 32'h1);
    setin(4'h1, 3'h0, 3'h0, 1'b0);
    duty <= 10'h1F4;
    h = 3'h0;
    for (j = 0; j < 1100; j++) begin
      cyc(1);
      if (j >= 3) chk(ga, h[2] ? 4'h9 : 4'h5);
      h = {h[1:0], pw[0]};
    end
    @(posedge clk);
    duty <= 10'h3FF;
  endtask

  // reset in mid-run: safe gates, settings back to defaults
  task automatic t_reset;
    setin(4'h0, 3'h0, 3'h0, 1'b0);
    cyc(4);
    @(posedge clk);
    rstn <= 1'b0;
    cyc(2);
    chk({ga, gb, gc, c1, c2, irq}, 15'h2A80);
    @(posedge clk);
    rstn <= 1'b1;
    rreg(4'h1);
    chk(v, 32'h0);
    rreg(4'h0);
    chk(v, 32'h0);
    rreg(4'h4);
    chk(v, 32'h0);
  endtask

  // verdict and end of run
  task automatic final_report;
    $display("errors=%0d checks=%0d", err_count, checked);
    if (err_count == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // reset, then every scenario in turn
  initial begin
    cyc(7);
    chk({ga, gb, gc, c1, c2, irq}, 15'h2A80);
    chk(rdata, 32'h0);
    @(posedge clk);
    rstn <= 1'b1;
    t_bridge;
    t_drvc;
    t_temp;
    t_limit;
    t_stat;
    t_pwm;
    t_reset;
    final_report;
  end
endmodule // mbpc_top_test
`default_nettype wire
